// ---- shared/srp_pkg.sv ----
// shared constants for the security register erase/program link
package srp_pkg;
    // command opcodes
    localparam logic [7:0] SRP_OP_WREN = 8'h06;
    localparam logic [7:0] SRP_OP_RDSR1 = 8'h05;
    localparam logic [7:0] SRP_OP_RDSR2 = 8'h35;
    localparam logic [7:0] SRP_OP_ERASE = 8'h44;
    localparam logic [7:0] SRP_OP_PROG = 8'h42;
    // storage layout
    localparam int SRP_NUM_REGS = 3;
    localparam int SRP_REG_BYTES = 256;
    localparam int SRP_MEM_BYTES = SRP_NUM_REGS * SRP_REG_BYTES;
    localparam logic [7:0] SRP_ERASED = 8'hff;
    // address select field: top byte zero, [11:8] zero, [15:12] = 1..3
    localparam logic [7:0] SRP_ADDR_TOP = 8'h00;
    localparam logic [3:0] SRP_ADDR_MID = 4'h0;
    localparam logic [3:0] SRP_SEL_FIRST = 4'h1;
    localparam logic [3:0] SRP_SEL_LAST = 4'h3;
    // status byte bit positions
    localparam int SRP_SR1_BUSY = 0;
    localparam int SRP_SR1_WEL = 1;
    localparam int SRP_SR2_LOCK_LSB = 3;
    // timing
    localparam int SRP_CLK_PERIOD_NS = 10;
    localparam int SRP_SE_TIME_US = 300;
    localparam int SRP_SE_CYC = SRP_SE_TIME_US * 1000 / SRP_CLK_PERIOD_NS;
    localparam int SRP_PP_TIME_US = 3;
    localparam logic [31:0] SRP_PP_CYC = 32'(SRP_PP_TIME_US * 1000 / SRP_CLK_PERIOD_NS);
    localparam logic [3:0] SRP_SCLK_HALF_LAST = 4'h7;
    // host register map and control fields
    localparam logic [3:0] SRP_REG_CTRL = 4'h0;
    localparam logic [3:0] SRP_REG_ADDR = 4'h4;
    localparam logic [3:0] SRP_REG_DATA = 4'h8;
    localparam logic [3:0] SRP_REG_STAT = 4'hc;
    localparam int SRP_CTRL_ADDR_BIT = 8;
    localparam int SRP_CTRL_DATA_BIT = 9;
    localparam int SRP_CTRL_READ_BIT = 10;
    localparam int SRP_FIFO_WIDTH = 8;
    localparam int SRP_FIFO_DEPTH = 32;
endpackage

// ---- shared/srp_link_if.sv ----
// serial link between host controller and flash device
`timescale 1ns/1ps
interface srp_link_if;
    logic sclk;
    logic csN;
    logic serialDataIn;
    logic serialDataOut;
    logic serialDataOutEn;
    modport host (
        output sclk,
        output csN,
        output serialDataIn,
        input serialDataOut,
        input serialDataOutEn
    );
    modport dev (
        input sclk,
        input csN,
        input serialDataIn,
        output serialDataOut,
        output serialDataOutEn
    );
endinterface

// ---- rtl/srp_flash_dev.sv ----
// flash device end: security register erase and program commands
//
// What this block does
// RL1: three independent 256-byte security registers
// RL2: erase needs write enable latch set
// RL3: erase is 44h plus 24-bit address
// RL4: address field selects register one to three
// RL5: erase only if deselect exactly after address
// RL6: busy held high for erase time
// RL7: status reads still answered while busy
// RL8: erase end clears write enable latch
// RL9: locked register ignores erase
// RL10: locked register ignores program
// RL11: program writes 1 to 256 bytes
// RL12: program needs write enable latch set
// RL13: program is 42h, address, data bytes
// RL14: host keeps select low whole program
// RL15: not recognised in four-wire command mode
// RL16: bits latched on serial clock rising edge
// RL17: program only clears bits, busy during program
`timescale 1ns/1ps
module srp_flash_dev
    import srp_pkg::*;
#(
    parameter int unsigned ERASE_CYC = SRP_SE_CYC
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic ce,
    srp_link_if.dev link,
    input wire logic fourWireMode,
    input wire logic [2:0] lockSet,
    output logic busy,
    output logic write_enable_latch_flag,
    output logic [2:0] lockBits
);
    logic [2:0] sclkS_q;
    logic [2:0] csS_q;
    logic [1:0] diS_q;
    logic [1:0] fwS_q;
    logic sclkRise, sclkFall, csN, csRise, di;
    logic [2:0] bitCnt_q;
    logic [2:0] byteCnt_q;
    logic [7:0] shReg_q;
    logic [7:0] rxByte;
    logic byteDone;
    logic [7:0] cmd_q;
    logic [23:0] addr_q;
    logic [23:0] newAddr;
    logic [7:0] wPtr_q;
    logic progOk_q, dataSeen_q;
    logic busy_q, wel_q;
    logic [2:0] lock_q;
    logic [31:0] opCnt_q;
    logic opErase_q;
    logic [1:0] opIdx_q;
    logic [7:0] mem_q [0:SRP_MEM_BYTES-1];
    logic [7:0] outSh_q;
    logic sdo_q, sdoEn_q;
    logic framed, rdActive, wrenOk, eraseOk, progStart, opDone;
    logic [1:0] selIdx, newIdx;

    // register select decode of a 24-bit address
    // RL4: select field one to three
    function automatic logic addrOk(input logic [23:0] a);
        return a[23:16] == SRP_ADDR_TOP && a[11:8] == SRP_ADDR_MID &&
            a[15:12] >= SRP_SEL_FIRST && a[15:12] <= SRP_SEL_LAST;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers, first stage read only by second
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            sclkS_q <= 3'h0;
            csS_q <= 3'h7;
            diS_q <= 2'h0;
            fwS_q <= 2'h0;
        end else if (ce) begin
            sclkS_q <= {sclkS_q[1:0], link.sclk};
            csS_q <= {csS_q[1:0], link.csN};
            diS_q <= {diS_q[0], link.serialDataIn};
            fwS_q <= {fwS_q[0], fourWireMode};
        end
    end

    // edge detection on synchronised pins
    assign sclkRise = sclkS_q[1] & ~sclkS_q[2];
    assign sclkFall = ~sclkS_q[1] & sclkS_q[2];
    assign csN = csS_q[1];
    assign csRise = csS_q[1] & ~csS_q[2];
    assign di = diS_q[1];
    assign rxByte = {shReg_q[6:0], di};
    // RL16: sample on rising edge
    assign byteDone = sclkRise & ~csN & (bitCnt_q == 3'h7);
    assign newAddr = {addr_q[15:0], rxByte};
    assign newIdx = newAddr[13:12] - 2'h1;
    assign selIdx = addr_q[13:12] - 2'h1;

    ////////////////////////////////////////////////////////////////////////
    // bit and byte framing
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            bitCnt_q <= 3'h0;
            byteCnt_q <= 3'h0;
            shReg_q <= 8'h00;
        end else if (ce) begin
            if (csN) begin
                bitCnt_q <= 3'h0;
                byteCnt_q <= 3'h0;
            end else if (sclkRise) begin
                shReg_q <= rxByte;
                bitCnt_q <= bitCnt_q + 3'h1;
                if (byteDone && byteCnt_q != 3'h4) begin
                    byteCnt_q <= byteCnt_q + 3'h1;
                end
            end
        end
    end

    // RL3: opcode then 24-bit address
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            cmd_q <= 8'h00;
            addr_q <= 24'h0;
        end else if (ce && byteDone) begin
            if (byteCnt_q == 3'h0) begin
                cmd_q <= rxByte;
            end else if (byteCnt_q != 3'h4) begin
                addr_q <= newAddr;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // command acceptance at deselect
    // RL5: deselect on byte boundary only
    assign framed = csRise & (bitCnt_q == 3'h0);
    // RL2: write enable latch gates erase
    // RL9: locked register ignores erase
    // RL15: refused in four-wire mode
    assign eraseOk = framed && cmd_q == SRP_OP_ERASE && byteCnt_q == 3'h4 &&
        !dataSeen_q && wel_q && !busy_q && !fwS_q[1] && addrOk(addr_q) &&
        !lock_q[selIdx];
    assign wrenOk = framed && cmd_q == SRP_OP_WREN && byteCnt_q == 3'h1 && !busy_q;
    assign progStart = csRise && progOk_q && dataSeen_q;
    assign opDone = busy_q && opCnt_q == 32'h1;

    // program permission, fixed once address is complete
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            progOk_q <= 1'b0;
            dataSeen_q <= 1'b0;
            wPtr_q <= 8'h00;
        end else if (ce) begin
            if (csN) begin
                progOk_q <= 1'b0;
                dataSeen_q <= 1'b0;
            end else if (byteDone && byteCnt_q == 3'h3) begin
                // RL12: write enable latch gates program
                // RL10: locked register ignores program
                // RL13: low address byte is start
                progOk_q <= cmd_q == SRP_OP_PROG && wel_q && !busy_q &&
                    !fwS_q[1] && addrOk(newAddr) && !lock_q[newIdx];
                wPtr_q <= rxByte;
            end else if (byteDone && byteCnt_q == 3'h4) begin
                dataSeen_q <= 1'b1;
                wPtr_q <= wPtr_q + 8'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // RL6: self-timed busy window
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            busy_q <= 1'b0;
            opCnt_q <= 32'h0;
            opErase_q <= 1'b0;
            opIdx_q <= 2'h0;
        end else if (ce) begin
            if (eraseOk) begin
                busy_q <= 1'b1;
                opCnt_q <= ERASE_CYC;
                opErase_q <= 1'b1;
                opIdx_q <= selIdx;
            end else if (progStart) begin
                // RL17: busy for program time
                busy_q <= 1'b1;
                opCnt_q <= SRP_PP_CYC;
                opErase_q <= 1'b0;
            end else if (opDone) begin
                busy_q <= 1'b0;
                opCnt_q <= 32'h0;
            end else if (busy_q) begin
                opCnt_q <= opCnt_q - 32'h1;
            end
        end
    end

    // RL8: latch cleared when operation ends
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            wel_q <= 1'b0;
        end else if (ce) begin
            if (wrenOk) begin
                wel_q <= 1'b1;
            end else if (opDone) begin
                wel_q <= 1'b0;
            end
        end
    end

    // RL9: one-time lock bits only set
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            lock_q <= 3'h0;
        end else if (ce) begin
            lock_q <= lock_q | lockSet;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // RL1: three registers in one array
    always_ff @(posedge clk_sys) begin
        if (ce) begin
            if (opDone && opErase_q) begin
                for (int i = 0; i < SRP_REG_BYTES; i++) begin
                    mem_q[{opIdx_q, 8'(i)}] <= SRP_ERASED;
                end
            end else if (byteDone && byteCnt_q == 3'h4 && progOk_q) begin
                // RL11: byte pointer wraps in register
                // RL17: programming only clears bits
                mem_q[{selIdx, wPtr_q}] <= mem_q[{selIdx, wPtr_q}] & rxByte;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // RL7: status reads answered while busy
    assign rdActive = byteCnt_q != 3'h0 &&
        (cmd_q == SRP_OP_RDSR1 || cmd_q == SRP_OP_RDSR2);

    // status shifter, msb out on falling edge
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            outSh_q <= 8'h00;
            sdo_q <= 1'b0;
            sdoEn_q <= 1'b0;
        end else if (ce) begin
            sdoEn_q <= !csN && rdActive;
            if (byteDone) begin
                outSh_q <= 8'h00;
                if ((byteCnt_q == 3'h0 ? rxByte : cmd_q) == SRP_OP_RDSR2) begin
                    outSh_q[SRP_SR2_LOCK_LSB +: 3] <= lock_q;
                end else begin
                    outSh_q[SRP_SR1_BUSY] <= busy_q;
                    outSh_q[SRP_SR1_WEL] <= wel_q;
                end
            end else if (sclkFall && !csN && rdActive) begin
                sdo_q <= outSh_q[7];
                outSh_q <= {outSh_q[6:0], 1'b0};
            end
        end
    end

    // outputs straight from flops
    assign link.serialDataOut = sdo_q;
    assign link.serialDataOutEn = sdoEn_q;
    assign busy = busy_q;
    assign write_enable_latch_flag = wel_q;
    assign lockBits = lock_q;
endmodule // srp_flash_dev

// ---- rtl/srp_host_ctrl.sv ----
// host end: serial link controller with data FIFO and register port
`timescale 1ns/1ps
module srp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic ce,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [0:DEPTH-1];
    logic [AW-1:0] wr_q, rd_q;
    logic [AW:0] cnt_q, cnt_d;
    logic push, pop, ready_q;

    assign push = inValid && ready_q;
    assign pop = outReady && cnt_q != '0;
    assign cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);

    // pointers, count and registered ready
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
            ready_q <= 1'b1;
        end else if (ce) begin
            wr_q <= wr_q + AW'(push);
            rd_q <= rd_q + AW'(pop);
            cnt_q <= cnt_d;
            ready_q <= cnt_d != (AW+1)'(DEPTH);
        end
    end

    // storage
    always_ff @(posedge clk_sys) begin
        if (ce && push) begin
            mem_q[wr_q] <= inData;
        end
    end

    assign inReady = ready_q;
    assign outValid = cnt_q != '0;
    assign outData = mem_q[rd_q];
endmodule // srp_fifo

////////////////////////////////////////////////////////////////////////////
module srp_host_ctrl
    import srp_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic ce,
    input wire logic [3:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdata,
    output logic fifoReady,
    output logic active,
    srp_link_if.host link
);
    typedef enum logic [1:0] {SRP_H_IDLE, SRP_H_SEL, SRP_H_SHIFT, SRP_H_DESEL} srp_hstate_t;
    srp_hstate_t state_q;
    logic [7:0] op_q;
    logic withAddr_q, withData_q, readByte_q, readDone_q;
    logic [23:0] addr_q;
    logic [3:0] div_q;
    logic tick;
    logic sclk_q, csN_q, di_q;
    logic [7:0] tx_q, rx_q, lastRx_q;
    logic [2:0] bit_q;
    logic [1:0] addrNo_q;
    logic [1:0] doS_q;
    logic [31:0] rdata_q;
    logic fifoInReady, fifoValid, fifoPop;
    logic [7:0] fifoData;
    logic byteEnd, ctrlGo;

    srp_fifo #(.WIDTH(SRP_FIFO_WIDTH), .DEPTH(SRP_FIFO_DEPTH)) u_fifo (
        .clk_sys(clk_sys),
        .reset(reset),
        .ce(ce),
        .inValid(regWr && regAddr == SRP_REG_DATA),
        .inReady(fifoInReady),
        .inData(regWdata[7:0]),
        .outValid(fifoValid),
        .outReady(fifoPop),
        .outData(fifoData)
    );

    assign tick = div_q == SRP_SCLK_HALF_LAST;
    assign byteEnd = state_q == SRP_H_SHIFT && tick && sclk_q && bit_q == 3'h7;
    assign ctrlGo = regWr && regAddr == SRP_REG_CTRL && state_q == SRP_H_IDLE;
    // data bytes drain the FIFO once address is out
    assign fifoPop = byteEnd && withData_q && addrNo_q == 2'h0 && fifoValid;

    // device output synchroniser
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            doS_q <= 2'h0;
        end else if (ce) begin
            doS_q <= {doS_q[0], link.serialDataOut};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // command registers
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            op_q <= 8'h00;
            withAddr_q <= 1'b0;
            withData_q <= 1'b0;
            readByte_q <= 1'b0;
            addr_q <= 24'h0;
        end else if (ce) begin
            if (ctrlGo) begin
                op_q <= regWdata[7:0];
                withAddr_q <= regWdata[SRP_CTRL_ADDR_BIT];
                withData_q <= regWdata[SRP_CTRL_DATA_BIT];
                readByte_q <= regWdata[SRP_CTRL_READ_BIT];
            end
            if (regWr && regAddr == SRP_REG_ADDR) begin
                addr_q <= regWdata[23:0];
            end
        end
    end

    // register read data, one cycle after strobe
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rdata_q <= 32'h0;
        end else if (ce && regRd) begin
            unique case (regAddr)
                SRP_REG_CTRL: rdata_q <= {21'h0, readByte_q, withData_q, withAddr_q, op_q};
                SRP_REG_ADDR: rdata_q <= {8'h00, addr_q};
                SRP_REG_STAT: rdata_q <= {16'h0, lastRx_q, 5'h0, fifoValid, fifoInReady,
                    state_q != SRP_H_IDLE};
                default: rdata_q <= 32'h0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // RL14: select held low across all bytes
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_q <= SRP_H_IDLE;
            div_q <= 4'h0;
            sclk_q <= 1'b0;
            csN_q <= 1'b1;
            di_q <= 1'b0;
            tx_q <= 8'h00;
            rx_q <= 8'h00;
            lastRx_q <= 8'h00;
            bit_q <= 3'h0;
            addrNo_q <= 2'h0;
            readDone_q <= 1'b0;
        end else if (ce) begin
            div_q <= tick ? 4'h0 : div_q + 4'h1;
            unique case (state_q)
                SRP_H_IDLE: begin
                    div_q <= 4'h0;
                    if (ctrlGo) begin
                        csN_q <= 1'b0;
                        state_q <= SRP_H_SEL;
                    end
                end
                SRP_H_SEL: if (tick) begin
                    // RL3: opcode goes first, msb first
                    tx_q <= {op_q[6:0], 1'b0};
                    di_q <= op_q[7];
                    bit_q <= 3'h0;
                    addrNo_q <= withAddr_q ? 2'h3 : 2'h0;
                    readDone_q <= 1'b0;
                    state_q <= SRP_H_SHIFT;
                end
                SRP_H_SHIFT: if (tick) begin
                    if (!sclk_q) begin
                        sclk_q <= 1'b1;
                        rx_q <= {rx_q[6:0], doS_q[1]};
                    end else begin
                        sclk_q <= 1'b0;
                        bit_q <= bit_q + 3'h1;
                        di_q <= tx_q[7];
                        tx_q <= {tx_q[6:0], 1'b0};
                        if (bit_q == 3'h7) begin
                            lastRx_q <= rx_q;
                            // RL13: address bytes, then data bytes
                            if (addrNo_q != 2'h0) begin
                                tx_q <= {addr_q[8*addrNo_q-2 -: 7], 1'b0};
                                di_q <= addr_q[8*addrNo_q-1];
                                addrNo_q <= addrNo_q - 2'h1;
                            end else if (fifoPop) begin
                                tx_q <= {fifoData[6:0], 1'b0};
                                di_q <= fifoData[7];
                            end else if (readByte_q && !readDone_q) begin
                                tx_q <= 8'h00;
                                di_q <= 1'b0;
                                readDone_q <= 1'b1;
                            end else begin
                                // RL5: deselect right after last bit
                                csN_q <= 1'b1;
                                state_q <= SRP_H_DESEL;
                            end
                        end
                    end
                end
                SRP_H_DESEL: if (tick) begin
                    state_q <= SRP_H_IDLE;
                end
            endcase
        end
    end

    assign link.sclk = sclk_q;
    assign link.csN = csN_q;
    assign link.serialDataIn = di_q;
    assign regRdata = rdata_q;
    assign fifoReady = fifoInReady;
    assign active = state_q != SRP_H_IDLE;
endmodule // srp_host_ctrl

// ---- dv/srp_link_checker.sv ----
// assertions on the link and device status
`timescale 1ns/1ps
module srp_link_checker (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic sclk,
    input wire logic csN,
    input wire logic serialDataIn,
    input wire logic serialDataOutEn,
    input wire logic busy,
    input wire logic write_enable_latch_flag
);
    localparam int MIN_BUSY = 290;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    logic [15:0] busyLen_q;
    // length of the running busy period
    always_ff @(posedge clk_sys) begin
        if (reset || !busy) busyLen_q <= 16'h0;
        else busyLen_q <= busyLen_q + 16'h1;
    end
    ////////////////////////////////////////////////////////////////////////////
    sequence s_half_high; sclk [*8] ##1 !sclk; endsequence
    sequence s_lead_low; !sclk [*4]; endsequence
    property p_idle_low; csN |-> !sclk; endproperty
    a_idle_low: assert property (p_idle_low) else $error("sclk high while deselected");
    property p_half; $rose(sclk) |-> s_half_high; endproperty
    a_half: assert property (p_half) else $error("bad sclk high phase");
    property p_lead; $fell(csN) |-> s_lead_low; endproperty
    a_lead: assert property (p_lead) else $error("sclk moved after select");
    property p_din; (!csN && sclk && $past(sclk)) |-> $stable(serialDataIn); endproperty
    a_din: assert property (p_din) else $error("data moved while sclk high");
    property p_oe; $rose(serialDataOutEn) |-> !csN; endproperty
    a_oe: assert property (p_oe) else $error("data driven while deselected");
    property p_busy_start; $rose(busy) |-> csN && $past(csN); endproperty
    a_busy_start: assert property (p_busy_start) else $error("busy began while selected");
    property p_busy_len; $fell(busy) |-> busyLen_q >= MIN_BUSY; endproperty
    a_busy_len: assert property (p_busy_len) else $error("busy period too short");
    property p_wel_clear; $fell(busy) |-> ##[0:2] !write_enable_latch_flag; endproperty
    a_wel_clear: assert property (p_wel_clear) else $error("wel kept after busy");
    property p_wel_set; $rose(write_enable_latch_flag) |-> !busy; endproperty
    a_wel_set: assert property (p_wel_set) else $error("wel set while busy");
endmodule // srp_link_checker

// ---- dv/security_register_erase_program_bench.sv ----
// bench joining host and device over the link
`timescale 1ns/1ps
module security_register_erase_program_bench;
    import srp_pkg::*;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic [3:0] regAddr = 4'h0;
    logic [31:0] regWdata = 32'h0;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic fourWireMode = 1'b0;
    logic [2:0] lockSet = 3'h0;
    logic [31:0] regRdata;
    logic fifoReady, active, busy, write_enable_latch_flag;
    logic [2:0] lockBits;
    int err_count = 0;
    int n_compared = 0;
    srp_link_if link ();
    srp_host_ctrl srp_host_ctrl_i (.clk_sys(clk_sys), .reset(reset), .ce(1'b1),
        .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(regRdata), .fifoReady(fifoReady), .active(active), .link(link));
    srp_flash_dev #(.ERASE_CYC(1000)) srp_flash_dev_i (.clk_sys(clk_sys), .reset(reset),
        .ce(1'b1), .link(link), .fourWireMode(fourWireMode), .lockSet(lockSet),
        .busy(busy), .write_enable_latch_flag(write_enable_latch_flag), .lockBits(lockBits));
    srp_link_checker srp_link_checker_i (.clk_sys(clk_sys), .reset(reset), .sclk(link.sclk),
        .csN(link.csN), .serialDataIn(link.serialDataIn),
        .serialDataOutEn(link.serialDataOutEn), .busy(busy), .write_enable_latch_flag(write_enable_latch_flag));
    // clock and watchdog
    initial forever #5 clk_sys = ~clk_sys;
    initial begin
        #1000000;
        err_count++;
        report_and_stop();
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge clk_sys);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk_sys);
        regRd <= 1'b0;
        @(negedge clk_sys);
        d = regRdata;
    endtask
    // start a transfer, poll until idle
    task automatic cmd(input logic [31:0] c);
        logic [31:0] s;
        wr(SRP_REG_CTRL, c);
        s = 32'h1;
        for (int i = 0; i < 4000 && s[0] === 1'b1; i++) rd(SRP_REG_STAT, s);
        chk("idle", s[0], 32'h0);
    endtask
    task automatic stat(input logic [7:0] op, output logic [7:0] b);
        logic [31:0] s;
        cmd({24'h000004, op});
        rd(SRP_REG_STAT, s);
        b = s[15:8];
    endtask
    task automatic erase(input logic [31:0] a);
        wr(SRP_REG_ADDR, a);
        cmd({24'h000001, SRP_OP_ERASE});
    endtask
    task automatic prog(input logic [31:0] a);
        wr(SRP_REG_ADDR, a);
        cmd({24'h000003, SRP_OP_PROG});
    endtask
    // judge whether busy shows, then wait for it to end
    task automatic go(input string what, input logic exp);
        logic seen;
        seen = 1'b0;
        for (int i = 0; i < 40; i++) begin
            @(negedge clk_sys);
            if (busy === 1'b1) seen = 1'b1;
        end
        for (int i = 0; i < 1200 && busy !== 1'b0; i++) @(negedge clk_sys);
        chk(what, seen, {31'h0, exp});
        chk("done", busy, 32'h0);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_erase();
        logic [7:0] b;
        erase(32'h00001000);
        go("no wel erase", 1'b0);
        for (int r = 1; r <= 3; r++) begin
            cmd({24'h0, SRP_OP_WREN});
            stat(SRP_OP_RDSR1, b);
            chk("wel set", b[SRP_SR1_WEL], 32'h1);
            erase({16'h0000, 4'(r), 4'h0, 8'ha5});
            stat(SRP_OP_RDSR1, b);
            chk("busy bit", b[SRP_SR1_BUSY], 32'h1);
            go("erase runs", 1'b1);
            chk("wel erase", write_enable_latch_flag, 32'h0);
        end
        $display("test erase done");
    endtask
    task automatic t_refuse();
        cmd({24'h0, SRP_OP_WREN});
        erase(32'h00004000);
        go("select four", 1'b0);
        erase(32'h00011000);
        go("top byte", 1'b0);
        cmd({24'h0, SRP_OP_ERASE});
        go("short erase", 1'b0);
        @(posedge clk_sys) fourWireMode <= 1'b1;
        erase(32'h00002000);
        go("four wire", 1'b0);
        @(posedge clk_sys) fourWireMode <= 1'b0;
        chk("wel kept", write_enable_latch_flag, 32'h1);
        $display("test refuse done");
    endtask
    task automatic t_prog();
        wr(SRP_REG_DATA, 32'h5a);
        wr(SRP_REG_DATA, 32'h3c);
        prog(32'h000020fe);
        go("program runs", 1'b1);
        chk("wel program", write_enable_latch_flag, 32'h0);
        wr(SRP_REG_DATA, 32'h11);
        prog(32'h00002010);
        go("no wel program", 1'b0);
        $display("test program done");
    endtask
    task automatic t_fifo();
        logic [31:0] s;
        cmd({24'h0, SRP_OP_WREN});
        for (int i = 0; i < 33; i++) wr(SRP_REG_DATA, 32'(i));
        rd(SRP_REG_STAT, s);
        chk("fifo full", s[2:1], 32'h2);
        prog(32'h00003000);
        go("long program", 1'b1);
        rd(SRP_REG_STAT, s);
        chk("fifo drained", s[2:1], 32'h1);
        $display("test fifo done");
    endtask
    task automatic t_lock();
        logic [7:0] b;
        @(posedge clk_sys) lockSet <= 3'h1;
        @(posedge clk_sys) lockSet <= 3'h0;
        repeat (4) @(posedge clk_sys);
        chk("lock bits", lockBits, 32'h1);
        stat(SRP_OP_RDSR2, b);
        chk("lock field", b[5:3], 32'h1);
        cmd({24'h0, SRP_OP_WREN});
        erase(32'h00001000);
        go("locked erase", 1'b0);
        wr(SRP_REG_DATA, 32'h00);
        prog(32'h00001000);
        go("locked program", 1'b0);
        erase(32'h00002000);
        go("unlocked erase", 1'b1);
        $display("test lock done");
    endtask
    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // reset, then scenarios
    initial begin
        logic [31:0] s;
        repeat (20) @(posedge clk_sys);
        reset <= 1'b0;
        rd(4'h2, s);
        chk("unmapped read", s, 32'h0);
        chk("reset state", {busy, write_enable_latch_flag, lockBits}, 32'h0);
        t_erase();
        t_refuse();
        t_prog();
        t_fifo();
        t_lock();
        report_and_stop();
    end
endmodule // security_register_erase_program_bench
